// *** logic/pgsc_pkg.sv ***
// package: constants, states and carriers for the group power-state controller
// assumes a single 250 MHz clock domain and no register bus
package pgsc_pkg;
  localparam int NUM_GROUPS   = 4;   // app, conn, modem, device-wide
  localparam int NUM_SUB      = 3;   // subsystem groups
  localparam int NUM_RES      = 8;   // assignable resources handled here
  localparam int NUM_DVS      = 4;   // regulators with dynamic voltage control
  localparam int NUM_TRIG     = 4;   // triggering event sources
  localparam int VSEL_W       = 7;   // voltage code width
  localparam int IDX_APP      = 0;
  localparam int IDX_CONN     = 1;
  localparam int IDX_MODEM    = 2;
  localparam int TRIG_WAKE    = 0;   // trigger: leave wait-on
  localparam int TRIG_OFF     = 1;   // trigger: back to wait-on
  localparam logic [NUM_DVS-1:0] DVS_CAPABLE = 4'hF;
  localparam logic [VSEL_W-1:0]  VSEL_RESET  = 7'h00;
  localparam logic [VSEL_W-1:0]  STEP_RESET  = 7'h01;
  localparam int STEP_TIME_NS = 100; // least time between two voltage steps
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_CYCLES  = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STEP_CYC = 8'(STEP_CYCLES);

  typedef enum logic [1:0] {
    GS_OFF, GS_WAIT_ON, GS_ACTIVE, GS_SLEEP
  } group_state_t;

  // resource operating mode driven to the analog side
  typedef enum logic [1:0] {
    RM_OFF, RM_LOW_POWER, RM_FULL
  } res_mode_t;

  // per-group request configuration
  typedef struct packed {
    logic app_mask;
    logic conn_mask;      // one shared mask for the three connectivity lines
    logic modem_mask;
    logic app_invert;
    logic conn_invert;
    logic modem_invert;
  } req_cfg_t;

  // one voltage-control command
  typedef struct packed {
    logic              valid;
    logic [1:0]        target;
    logic [VSEL_W-1:0] active_code;
    logic [VSEL_W-1:0] sleep_code;
  } vc_cmd_t;
endpackage : pgsc_pkg

// *** logic/req_sync.sv ***
// two-stage synchroniser bank for the request pins
// assumes the pins are asynchronous to ref_clk
module req_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,    // controller clock
  input  wire logic         rst_n,  // synchronised reset
  input  wire logic [W-1:0] async_in, // raw pins
  output logic      [W-1:0] sync_out  // synchronised copy
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // first stage only feeds the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : req_sync

// *** logic/vstep.sv ***
// slew-limited voltage code for one regulator
// assumes target and step are static-ish configuration from the same clock
module vstep (
  input  wire logic                     clk,    // controller clock
  input  wire logic                     rst_n,  // synchronised reset
  input  wire logic [pgsc_pkg::VSEL_W-1:0] target, // wanted code
  input  wire logic [pgsc_pkg::VSEL_W-1:0] step,   // max change per step
  output logic      [pgsc_pkg::VSEL_W-1:0] vout,   // applied code
  output logic                          busy    // still ramping
);
  logic [pgsc_pkg::VSEL_W-1:0] v_reg;
  logic [pgsc_pkg::VSEL_W-1:0] v_next;
  logic [7:0]                  t_reg;
  logic [7:0]                  t_next;
  logic [pgsc_pkg::VSEL_W-1:0] st;

  // move toward target by at most step every step period
  always_comb begin
    v_next = v_reg;
    t_next = t_reg;
    st     = (step == '0) ? {{(pgsc_pkg::VSEL_W-1){1'b0}}, 1'b1} : step; // zero step would stall
    if (t_reg != 8'h00) begin
      t_next = t_reg - 8'h01;
    end else if (v_reg != target) begin
      if (target > v_reg) begin
        v_next = ((target - v_reg) > st) ? v_reg + st : target;
      end else begin
        v_next = ((v_reg - target) > st) ? v_reg - st : target;
      end
      t_next = pgsc_pkg::STEP_CYC - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v_reg <= pgsc_pkg::VSEL_RESET;
      t_reg <= 8'h00;
    end else begin
      v_reg <= v_next;
      t_reg <= t_next;
    end
  end

  assign vout = v_reg;
  assign busy = (v_reg != target) || (t_reg != 8'h00);
endmodule : vstep

// *** logic/power_group_state_control.sv ***
// group power-state controller: request lines, group states, resource modes,
// dynamic voltage commands. assumes one 250 MHz clock, config bits as ports
module power_group_state_control (
  input  wire logic                    ref_clk,        // 250 MHz controller clock
  input  wire logic                    resetn,         // async active-low reset
  input  wire logic                    app_group_request,    // pin
  input  wire logic                    conn_group_request_a, // pin
  input  wire logic                    conn_group_request_b, // pin
  input  wire logic                    conn_group_request_c, // pin
  input  wire logic                    modem_group_request,  // pin
  input  wire pgsc_pkg::req_cfg_t      req_cfg,        // masks and polarity
  input  wire logic [pgsc_pkg::NUM_TRIG-1:0] trig_event,  // trigger pulses
  input  wire logic [pgsc_pkg::NUM_TRIG-1:0] trig_enable, // per-trigger enables
  input  wire logic [pgsc_pkg::NUM_RES-1:0]  assign_app,  // group assignment attribute
  input  wire logic [pgsc_pkg::NUM_RES-1:0]  assign_conn, // group assignment attribute
  input  wire logic [pgsc_pkg::NUM_RES-1:0]  assign_modem,// group assignment attribute
  input  wire logic [pgsc_pkg::NUM_RES-1:0]  transition_config_en,   // override on
  input  wire logic [2*pgsc_pkg::NUM_RES-1:0] transition_config_mode, // override mode
  input  wire pgsc_pkg::vc_cmd_t       voltage_control_port, // command strobe
  input  wire logic [pgsc_pkg::VSEL_W-1:0] vstep_size, // slew step
  input  wire logic [pgsc_pkg::VSEL_W-1:0] fixed_vsel, // fixed supply setting
  output logic [2*pgsc_pkg::NUM_GROUPS-1:0] group_state,  // state register view
  output logic [2*pgsc_pkg::NUM_RES-1:0]    res_mode,     // per-resource mode
  output logic [1:0]                   device_res_mode,     // hard-wired resources
  output logic                         pm_reset_released,   // controller reset off
  output logic                         system_reset_out,    // high = reset active
  output logic [pgsc_pkg::NUM_DVS*pgsc_pkg::VSEL_W-1:0] dvs_vsel, // applied codes
  output logic [pgsc_pkg::NUM_DVS-1:0] dvs_busy,            // ramp in progress
  output logic [pgsc_pkg::VSEL_W-1:0]  fixed_vout,          // fixed supply code
  output logic                         vc_reject            // command refused
);
  // reset release through two flops
  logic rst_s1_reg;
  logic rst_n;
  logic rst_n_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end
  assign rst_n = rst_n_reg;

  // request synchronisers
  logic [4:0] req_raw;
  logic [4:0] req_s;
  assign req_raw = {modem_group_request, conn_group_request_c, conn_group_request_b,
                    conn_group_request_a, app_group_request};

  req_sync #(.W(5)) u_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in (req_raw),
    .sync_out (req_s)
  );

  // polarity then mask per group
  function automatic logic req_fn(input logic lvl, input logic inv, input logic msk);
    req_fn = (lvl ^ inv) & ~msk;
  endfunction : req_fn

  logic [pgsc_pkg::NUM_SUB-1:0] sub_req;
  always_comb begin
    sub_req[pgsc_pkg::IDX_APP]   = req_fn(req_s[0], req_cfg.app_invert,
                                          req_cfg.app_mask);
    sub_req[pgsc_pkg::IDX_CONN]  = req_fn(req_s[1], req_cfg.conn_invert, req_cfg.conn_mask)
                                 | req_fn(req_s[2], req_cfg.conn_invert, req_cfg.conn_mask)
                                 | req_fn(req_s[3], req_cfg.conn_invert,
                                          req_cfg.conn_mask);
    sub_req[pgsc_pkg::IDX_MODEM] = req_fn(req_s[4], req_cfg.modem_invert,
                                          req_cfg.modem_mask);
  end

  // gated triggers: disabled events are dropped
  logic [pgsc_pkg::NUM_TRIG-1:0] trig_ok;
  assign trig_ok = trig_event & trig_enable;

  // device-wide group state and subsystem group states
  pgsc_pkg::group_state_t dev_reg;
  pgsc_pkg::group_state_t dev_next;
  pgsc_pkg::group_state_t sub_reg  [pgsc_pkg::NUM_SUB];
  pgsc_pkg::group_state_t sub_next [pgsc_pkg::NUM_SUB];
  logic                   all_sleep;

  always_comb begin
    all_sleep = 1'b1;
    for (int g = 0; g < pgsc_pkg::NUM_SUB; g++) begin
      all_sleep = all_sleep & (sub_reg[g] == pgsc_pkg::GS_SLEEP);
    end
  end

  // device group: off -> wait-on after reset, active on wake trigger
  always_comb begin
    dev_next = dev_reg;
    case (dev_reg)
      pgsc_pkg::GS_OFF: begin
        dev_next = pgsc_pkg::GS_WAIT_ON;
      end
      pgsc_pkg::GS_WAIT_ON: begin
        if (trig_ok[pgsc_pkg::TRIG_WAKE]) begin
          dev_next = pgsc_pkg::GS_ACTIVE;
        end
      end
      pgsc_pkg::GS_ACTIVE: begin
        if (trig_ok[pgsc_pkg::TRIG_OFF]) begin
          dev_next = pgsc_pkg::GS_WAIT_ON;
        end else if (all_sleep) begin
          dev_next = pgsc_pkg::GS_SLEEP;
        end
      end
      pgsc_pkg::GS_SLEEP: begin
        if (trig_ok[pgsc_pkg::TRIG_OFF]) begin
          dev_next = pgsc_pkg::GS_WAIT_ON;
        end else if (!all_sleep) begin
          dev_next = pgsc_pkg::GS_ACTIVE;
        end
      end
      default: begin
        dev_next = pgsc_pkg::GS_OFF;
      end
    endcase
  end

  // subsystem groups follow their request while the device is up;
  // voltage commands are not an input here, so they cannot move a state
  always_comb begin
    for (int g = 0; g < pgsc_pkg::NUM_SUB; g++) begin
      sub_next[g] = sub_reg[g];
      case (dev_reg)
        pgsc_pkg::GS_ACTIVE, pgsc_pkg::GS_SLEEP: begin
          case (sub_reg[g])
            pgsc_pkg::GS_OFF: begin
              sub_next[g] = sub_req[g] ? pgsc_pkg::GS_ACTIVE : pgsc_pkg::GS_SLEEP;
            end
            pgsc_pkg::GS_ACTIVE: begin
              if (!sub_req[g]) begin
                sub_next[g] = pgsc_pkg::GS_SLEEP;
              end
            end
            pgsc_pkg::GS_SLEEP: begin
              if (sub_req[g]) begin
                sub_next[g] = pgsc_pkg::GS_ACTIVE;
              end
            end
            default: begin
              sub_next[g] = pgsc_pkg::GS_OFF;
            end
          endcase
        end
        default: begin
          sub_next[g] = pgsc_pkg::GS_OFF;
        end
      endcase
    end
  end

  // group state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_reg <= pgsc_pkg::GS_OFF;
      for (int g = 0; g < pgsc_pkg::NUM_SUB; g++) begin
        sub_reg[g] <= pgsc_pkg::GS_OFF;
      end
    end else begin
      dev_reg <= dev_next;
      for (int g = 0; g < pgsc_pkg::NUM_SUB; g++) begin
        sub_reg[g] <= sub_next[g];
      end
    end
  end

  always_comb begin
    for (int g = 0; g < pgsc_pkg::NUM_SUB; g++) begin
      group_state[2*g +: 2] = sub_reg[g];
    end
    group_state[2*pgsc_pkg::NUM_SUB +: 2] = dev_reg;
  end

  // map group state to resource mode
  function automatic pgsc_pkg::res_mode_t mode_of(input pgsc_pkg::group_state_t s);
    case (s)
      pgsc_pkg::GS_ACTIVE: mode_of = pgsc_pkg::RM_FULL;
      pgsc_pkg::GS_SLEEP:  mode_of = pgsc_pkg::RM_LOW_POWER;
      default:             mode_of = pgsc_pkg::RM_OFF;
    endcase
  endfunction : mode_of

  // arbitration: the strongest mode among assigned groups wins
  // an override only reshapes an awake resource; an unassigned one stays off
  logic [2*pgsc_pkg::NUM_RES-1:0] res_mode_reg;
  logic [2*pgsc_pkg::NUM_RES-1:0] res_mode_flat;

  always_comb begin
    pgsc_pkg::res_mode_t m;
    pgsc_pkg::res_mode_t c;
    m = pgsc_pkg::RM_OFF;
    c = pgsc_pkg::RM_OFF;
    for (int r = 0; r < pgsc_pkg::NUM_RES; r++) begin
      m = pgsc_pkg::RM_OFF;
      if (assign_app[r]) begin
        c = mode_of(sub_reg[pgsc_pkg::IDX_APP]);
        if (c > m) m = c;
      end
      if (assign_conn[r]) begin
        c = mode_of(sub_reg[pgsc_pkg::IDX_CONN]);
        if (c > m) m = c;
      end
      if (assign_modem[r]) begin
        c = mode_of(sub_reg[pgsc_pkg::IDX_MODEM]);
        if (c > m) m = c;
      end
      if (transition_config_en[r] && (m != pgsc_pkg::RM_OFF)) begin
        m = pgsc_pkg::res_mode_t'(transition_config_mode[2*r +: 2]);
      end
      res_mode_flat[2*r +: 2] = m;
    end
  end

  // mode outputs registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_mode_reg <= '0;
    end else begin
      res_mode_reg <= res_mode_flat;
    end
  end
  assign res_mode = res_mode_reg;

  // hard-wired device resources and resets
  logic [1:0] dev_mode_reg;
  logic       pm_rel_reg;
  logic       sys_rst_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_mode_reg <= 2'h0;
      pm_rel_reg   <= 1'b0;
      sys_rst_reg  <= 1'b1;
    end else begin
      dev_mode_reg <= mode_of(dev_reg);
      pm_rel_reg   <= (dev_reg != pgsc_pkg::GS_OFF);
      sys_rst_reg  <= (dev_reg == pgsc_pkg::GS_OFF) ||
                      (dev_reg == pgsc_pkg::GS_WAIT_ON);
    end
  end
  assign device_res_mode   = dev_mode_reg;
  assign pm_reset_released = pm_rel_reg;
  assign system_reset_out  = sys_rst_reg;

  // voltage command store: active and sleep code per regulator
  logic [pgsc_pkg::VSEL_W-1:0] act_code_reg [pgsc_pkg::NUM_DVS];
  logic [pgsc_pkg::VSEL_W-1:0] slp_code_reg [pgsc_pkg::NUM_DVS];
  logic [pgsc_pkg::VSEL_W-1:0] act_code_next [pgsc_pkg::NUM_DVS];
  logic [pgsc_pkg::VSEL_W-1:0] slp_code_next [pgsc_pkg::NUM_DVS];
  logic                        rej_next;
  logic                        rej_reg;

  always_comb begin
    for (int d = 0; d < pgsc_pkg::NUM_DVS; d++) begin
      act_code_next[d] = act_code_reg[d];
      slp_code_next[d] = slp_code_reg[d];
    end
    rej_next = 1'b0;
    if (voltage_control_port.valid) begin
      if (pgsc_pkg::DVS_CAPABLE[voltage_control_port.target]) begin
        act_code_next[voltage_control_port.target] = voltage_control_port.active_code;
        slp_code_next[voltage_control_port.target] = voltage_control_port.sleep_code;
      end else begin
        rej_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int d = 0; d < pgsc_pkg::NUM_DVS; d++) begin
        act_code_reg[d] <= pgsc_pkg::VSEL_RESET;
        slp_code_reg[d] <= pgsc_pkg::VSEL_RESET;
      end
      rej_reg <= 1'b0;
    end else begin
      for (int d = 0; d < pgsc_pkg::NUM_DVS; d++) begin
        act_code_reg[d] <= act_code_next[d];
        slp_code_reg[d] <= slp_code_next[d];
      end
      rej_reg <= rej_next;
    end
  end
  assign vc_reject = rej_reg;

  // regulator d tracks resource d; its registered resource mode picks the code, low power the sleep one
  for (genvar d = 0; d < pgsc_pkg::NUM_DVS; d++) begin : g_dvs
    logic [pgsc_pkg::VSEL_W-1:0] tgt;
    assign tgt = (res_mode_reg[2*d +: 2] == pgsc_pkg::RM_LOW_POWER) ?
                 slp_code_reg[d] : act_code_reg[d];
    vstep u_step (
      .clk    (ref_clk),
      .rst_n  (rst_n),
      .target (tgt),
      .step   (vstep_size),
      .vout   (dvs_vsel[d*pgsc_pkg::VSEL_W +: pgsc_pkg::VSEL_W]),
      .busy   (dvs_busy[d])
    );
  end

  // fixed-output supply takes its own setting
  logic [pgsc_pkg::VSEL_W-1:0] fix_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fix_reg <= pgsc_pkg::VSEL_RESET;
    end else begin
      fix_reg <= fixed_vsel;
    end
  end
  assign fixed_vout = fix_reg;
endmodule : power_group_state_control

// *** verification/pgsc_sva.sv ***
// checker: port-level properties of the group power-state controller
// assumes it is bound to power_group_state_control, one clock domain
module pgsc_sva (
  input wire logic                      ref_clk,              // clock
  input wire logic                      resetn,               // async reset
  input wire logic                      app_group_request,    // pin
  input wire logic                      modem_group_request,  // pin
  input wire pgsc_pkg::req_cfg_t        req_cfg,              // masks, polarity
  input wire logic [3:0]                trig_event,           // triggers
  input wire logic [3:0]                trig_enable,          // enables
  input wire pgsc_pkg::vc_cmd_t         voltage_control_port, // command
  input wire logic [7:0]                group_state,          // states
  input wire logic [1:0]                device_res_mode,      // fixed modes
  input wire logic                      pm_reset_released,    // ctrl reset off
  input wire logic                      system_reset_out,     // system reset
  input wire logic [27:0]               dvs_vsel,             // codes
  input wire logic                      vc_reject             // refusal
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  wire logic [1:0] dev       = group_state[7:6];

  // four settled samples cover the two sync flops plus the state update;
  // pin and polarity held apart, as the design flips polarity after the sync
  property follow_p(logic [1:0] st, logic msk, logic pin, logic inv);
    (dev == pgsc_pkg::GS_ACTIVE && !msk && $stable(pin) && $stable(inv)) [*4]
      |=> st == (($past(pin) ^ $past(inv)) ? pgsc_pkg::GS_ACTIVE : pgsc_pkg::GS_SLEEP);
  endproperty

  dev_sleep_entry_a: assert property (
    dev == pgsc_pkg::GS_SLEEP && $past(dev) != pgsc_pkg::GS_SLEEP
      |-> $past(group_state[5:0]) == 6'h3F) else $error("device slept early");
  waiton_subs_off_a: assert property (
    dev == pgsc_pkg::GS_WAIT_ON && $past(dev) == pgsc_pkg::GS_WAIT_ON
      |-> group_state[5:0] == 6'h00) else $error("subsystem awake in wait-on");
  pm_reset_follow_a: assert property (
    pm_reset_released == ($past(dev) != pgsc_pkg::GS_OFF)) else $error("pm reset wrong");
  sys_reset_rel_a: assert property (
    dev == pgsc_pkg::GS_ACTIVE && $past(dev) == pgsc_pkg::GS_ACTIVE
      |-> !system_reset_out) else $error("system reset held in active");
  wake_enabled_a: assert property (
    dev == pgsc_pkg::GS_WAIT_ON && trig_event[0] && trig_enable[0]
      && !(trig_event[1] && trig_enable[1]) |=> dev == pgsc_pkg::GS_ACTIVE)
    else $error("enabled wake lost");
  wake_ignored_a: assert property (
    dev == pgsc_pkg::GS_WAIT_ON && !(trig_event[0] && trig_enable[0])
      |=> dev == pgsc_pkg::GS_WAIT_ON) else $error("left wait-on unasked");
  app_follow_a: assert property (follow_p(group_state[1:0], req_cfg.app_mask,
    app_group_request, req_cfg.app_invert)) else $error("application group ignores its request");
  modem_follow_a: assert property (follow_p(group_state[5:4], req_cfg.modem_mask,
    modem_group_request, req_cfg.modem_invert)) else $error("modem group ignores its request");
  dev_res_mode_a: assert property (
    dev inside {pgsc_pkg::GS_ACTIVE, pgsc_pkg::GS_SLEEP} |=> device_res_mode ==
      ($past(dev) == pgsc_pkg::GS_ACTIVE ? pgsc_pkg::RM_FULL : pgsc_pkg::RM_LOW_POWER))
    else $error("device resources wrong mode");
  vc_accept_a: assert property (
    voltage_control_port.valid && pgsc_pkg::DVS_CAPABLE[voltage_control_port.target]
      |=> !vc_reject) else $error("capable target refused");
  slew_hold_a: assert property (
    $changed(dvs_vsel[6:0]) |=> $stable(dvs_vsel[6:0]) [*8]) else $error("ramp too fast");

  cover property (dev == pgsc_pkg::GS_WAIT_ON ##1 dev == pgsc_pkg::GS_ACTIVE);
  cover property (dev == pgsc_pkg::GS_SLEEP);
  cover property (voltage_control_port.valid);
endmodule : pgsc_sva

bind power_group_state_control pgsc_sva pgsc_sva_u (.ref_clk, .resetn, .app_group_request,
  .modem_group_request, .req_cfg, .trig_event, .trig_enable, .voltage_control_port,
  .group_state, .device_res_mode, .pm_reset_released, .system_reset_out, .dvs_vsel, .vc_reject);

// *** verification/subsys_model.sv ***
// partner: subsystem processors driving the five request pins
// assumes wishes arrive from the bench; pins move on falling edges, unrelated to sampling
module subsys_model (
  input  wire logic       ref_clk, // controller clock
  input  wire logic [4:0] want,    // app, conn a/b/c, modem wish to be active
  input  wire logic [2:0] inv,     // app, conn, modem polarity inverted
  input  wire logic       slow,    // answer two cycles late
  output logic      [4:0] pins     // request pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lag1_reg; // delayed wish of a slow processor
  logic [4:0] lag2_reg; // second delay stage
  initial pins = 5'h00;
  // level high means active unless the polarity bit flips it
  always @(negedge ref_clk) begin
    lag1_reg <= want;
    lag2_reg <= lag1_reg;
    pins     <= (slow ? lag2_reg : want) ^ {inv[2], {3{inv[1]}}, inv[0]};
  end
endmodule : subsys_model

// *** verification/power_group_state_control_tb.sv ***
// bench: random request patterns against an integer model of group states
// assumes 250 MHz ref_clk and the subsystem partner model beside the design
module power_group_state_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk     = 1'b0;
  logic               resetn      = 1'b0;
  pgsc_pkg::req_cfg_t req_cfg     = '0;
  logic [3:0]         trig_event  = 4'h0;
  logic [3:0]         trig_enable = 4'h0;
  logic [7:0]         assign_app  = 8'h00;
  logic [7:0]         assign_conn = 8'h00;
  logic [7:0]         assign_modem = 8'h00;
  logic [7:0]         tc_en       = 8'h00;
  logic [15:0]        tc_mode     = 16'h0000;
  pgsc_pkg::vc_cmd_t  vc          = '0;
  logic [6:0]         vstep_size  = 7'h01;
  logic [6:0]         fixed_vsel  = 7'h00;
  logic [4:0]         want        = 5'h00;
  logic               slow        = 1'b0;
  logic [4:0]         pins;
  logic [7:0]         group_state;
  logic [15:0]        res_mode;
  logic [1:0]         device_res_mode;
  logic               pm_reset_released;
  logic               system_reset_out;
  logic [27:0]        dvs_vsel;
  logic [3:0]         dvs_busy;
  logic [6:0]         fixed_vout;
  logic               vc_reject;
  int                 n_mismatch  = 0;
  int                 compares    = 0;
  int                 cyc         = 0;
  logic [31:0]        rng         = 32'h724B6C01;

  always #2 ref_clk = ~ref_clk;

  subsys_model u_subsys (.ref_clk, .want, .inv(req_cfg[2:0]), .slow, .pins);

  power_group_state_control dut_u (.ref_clk, .resetn, .app_group_request(pins[4]),
    .conn_group_request_a(pins[3]), .conn_group_request_b(pins[2]),
    .conn_group_request_c(pins[1]), .modem_group_request(pins[0]), .req_cfg,
    .trig_event, .trig_enable, .assign_app, .assign_conn, .assign_modem,
    .transition_config_en(tc_en), .transition_config_mode(tc_mode),
    .voltage_control_port(vc), .vstep_size, .fixed_vsel, .group_state, .res_mode,
    .device_res_mode, .pm_reset_released, .system_reset_out, .dvs_vsel, .dvs_busy,
    .fixed_vout, .vc_reject);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // group state to resource mode: active full, sleep low power, else off
  function automatic int gm(input int s);
    return (s == 2) ? 2 : ((s == 3) ? 1 : 0);
  endfunction : gm

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // one trigger pulse, one cycle wide
  task automatic pulse(input logic [3:0] ev);
    @(posedge ref_clk);
    trig_event <= ev;
    @(posedge ref_clk);
    trig_event <= 4'h0;
    repeat (6) @(posedge ref_clk);
  endtask : pulse

  // hang guard, far above the longest ramp sequence
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    int         sub[3];
    int         dev;
    int         exp_rm;
    int         n;
    int         prev[4];
    logic [7:0] asg[3];
    logic [7:0] gs0;
    logic [6:0] code;
    logic [31:0] r2;
    prev = '{0, 0, 0, 0};
    repeat (3) @(posedge ref_clk);
    chk("reset states", 32'h0, 32'(group_state));
    chk("reset sysrst", 32'h1, 32'(system_reset_out));
    resetn <= 1'b1;
    want   <= 5'h1F;
    repeat (8) @(posedge ref_clk);
    chk("wait-on", 32'h40, 32'(group_state));
    chk("pm reset", 32'h1, 32'(pm_reset_released));
    pulse(4'h1);
    chk("wake disabled", 32'h40, 32'(group_state));
    trig_enable <= 4'h3;
    pulse(4'h1);
    chk("wake", 32'hAA, 32'(group_state));
    chk("sysrst out", 32'h0, 32'(system_reset_out));
    // random request, mask, polarity and assignment mixes; every fifth all quiet
    for (int it = 0; it < 30; it++) begin
      rng = xs(rng);
      r2  = xs(rng);
      @(posedge ref_clk);
      want         <= (it % 5 == 0) ? 5'h00 : rng[4:0];
      req_cfg      <= pgsc_pkg::req_cfg_t'({rng[7:5] & rng[13:11], rng[10:8]});
      assign_app   <= rng[23:16];
      assign_conn  <= rng[31:24];
      assign_modem <= r2[15:8];
      tc_en        <= r2[7:0] & r2[23:16];
      tc_mode      <= r2[31:16] & ~(r2[30:15] & 16'hAAAA);
      slow         <= r2[1];
      fixed_vsel   <= r2[6:0];
      repeat (14) @(posedge ref_clk);
      sub[0] = (!req_cfg.app_mask && want[4]) ? 2 : 3;
      sub[1] = (!req_cfg.conn_mask && (|want[3:1])) ? 2 : 3;
      sub[2] = (!req_cfg.modem_mask && want[0]) ? 2 : 3;
      dev = (sub[0] == 3 && sub[1] == 3 && sub[2] == 3) ? 3 : 2;
      chk("states", 32'(dev * 64 + sub[2] * 16 + sub[1] * 4 + sub[0]), 32'(group_state));
      chk("dev res", 32'((dev == 2) ? 2 : 1), 32'(device_res_mode));
      chk("fixed", 32'(fixed_vsel), 32'(fixed_vout));
      asg = '{assign_app, assign_conn, assign_modem};
      for (int i = 0; i < 8; i++) begin
        exp_rm = 0;
        foreach (sub[g]) begin
          if (asg[g][i] && gm(sub[g]) > exp_rm) begin
            exp_rm = gm(sub[g]);
          end
        end
        if (tc_en[i] && exp_rm != 0) begin
          exp_rm = int'(tc_mode[2*i+:2]);
        end
        chk("res mode", 32'(exp_rm), 32'(res_mode[2*i+:2]));
      end
    end
    // voltage commands to each regulator while its group runs
    @(posedge ref_clk);
    want <= 5'h1F;
    req_cfg <= '0;
    assign_app <= 8'h0F;
    assign_conn <= 8'h00;
    assign_modem <= 8'h00; // resources no other group uses are unassigned
    tc_en <= 8'h00;
    repeat (14) @(posedge ref_clk);
    for (int t = 0; t < 4; t++) begin
      rng  = xs(rng);
      code = rng[6:0];
      gs0  = group_state;
      @(posedge ref_clk);
      vstep_size <= 7'(rng[9:7]) + 7'h01;
      vc <= '{1'b1, 2'(t), code, ~code};
      @(posedge ref_clk);
      vc.valid <= 1'b0;
      #1;
      chk("reject", 32'h0, 32'(vc_reject));
      n = 0;
      while ((dvs_vsel[7*t+:7] !== code || dvs_busy[t] !== 1'b0) && n < 4000) begin
        @(posedge ref_clk);
        n++;
      end
      chk("code", 32'(code), 32'(dvs_vsel[7*t+:7]));
      exp_rm = (prev[t] > int'(code)) ? prev[t] - int'(code) : int'(code) - prev[t];
      exp_rm = (exp_rm + int'(vstep_size) - 1) / int'(vstep_size);
      chk("ramp slow", 32'h1, 32'(n >= pgsc_pkg::STEP_CYCLES * (exp_rm - 1)));
      chk("state kept", 32'(gs0), 32'(group_state));
      prev[t] = int'(code);
    end
    // application group sleeps: its regulators ramp to their sleep codes
    @(posedge ref_clk);
    want <= 5'h0F;
    repeat (3300) @(posedge ref_clk);
    chk("sleep code", 32'(7'(~prev[0])), 32'(dvs_vsel[6:0]));
    pulse(4'h2);
    repeat (4) @(posedge ref_clk);
    chk("off trigger", 32'h40, 32'(group_state));
    tally_and_finish();
  end
endmodule : power_group_state_control_tb
